// File: inc/acc_pkg.sv
// constants, register map and carrier types for the adc compander block
package acc_pkg;
   // ==========================================================
   // control word and register map
   localparam int CW_W = 16;
   localparam int ADDR_W = 7;
   localparam int REG_W = 9;
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
   localparam logic [6:0] ADDR_POWER_ONE = 7'h01;
   localparam logic [6:0] ADDR_COMPAND = 7'h05;
   localparam logic [6:0] ADDR_CLOCK_CTL = 7'h06;
   localparam logic [6:0] ADDR_EXTRA = 7'h07;
   localparam logic [6:0] ADDR_INT_RATIO = 7'h24;
   localparam logic [6:0] ADDR_FRAC_HIGH = 7'h25;
   localparam logic [6:0] ADDR_FRAC_MID = 7'h26;
   localparam logic [6:0] ADDR_FRAC_LOW = 7'h27;
   localparam logic [8:0] RST_POWER_ONE = 9'h000;
   localparam logic [8:0] RST_COMPAND = 9'h000;
   localparam logic [8:0] RST_CLOCK_CTL = 9'h140;
   localparam logic [8:0] RST_EXTRA = 9'h000;
   localparam logic [8:0] RST_INT_RATIO = 9'h008;
   localparam logic [8:0] RST_FRAC_HIGH = 9'h00c;
   localparam logic [8:0] RST_FRAC_MID = 9'h093;
   localparam logic [8:0] RST_FRAC_LOW = 9'h0e9;
   // ==========================================================
   // field positions
   localparam int MULT_ON_BIT = 5;
   localparam int COMP_LSB = 1;
   localparam int RATE_LSB = 1;
   localparam int CLK_SRC_BIT = 8;
   localparam int CLK_DIV_LSB = 5;
   localparam int HALVER_BIT = 4;
   localparam int FRAC_HIGH_W = 6;
   localparam logic [1:0] COMP_LINEAR = 2'h0;
   localparam logic [1:0] COMP_MULAW = 2'h2;
   localparam logic [1:0] COMP_ALAW = 2'h3;
   localparam logic [2:0] CLK_DIV_TWO = 3'h2;
   // ==========================================================
   // data path and clock dividers
   localparam int SAMPLE_W = 24;
   localparam int CODE_W = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [7:0] MULAW_INVERT = 8'hff;
   localparam logic [7:0] ALAW_INVERT = 8'h55;
   localparam logic [12:0] MULAW_BIAS = 13'h0021;
   localparam logic [2:0] FIXED_DIV_LAST = 3'h3;
   localparam logic [2:0] HALVED_DIV_LAST = 3'h7;

   typedef enum logic [2:0] {
      MODE_LINEAR = 3'b001,
      MODE_MULAW = 3'b010,
      MODE_ALAW = 3'b100
   } acc_mode_type;

   typedef struct packed {
      logic [6:0] addr;
      logic [8:0] data;
   } acc_ctrl_word_type;

   typedef struct packed {
      logic [8:0] power_management_one;
      logic [8:0] compand_control;
      logic [8:0] clock_control;
      logic [8:0] extra_control;
      logic [8:0] multiplier_integer_ratio;
      logic [8:0] multiplier_fraction_high;
      logic [8:0] multiplier_fraction_mid;
      logic [8:0] multiplier_fraction_low;
   } acc_regs_type;

   typedef struct packed {
      logic [2:0] rate_code;
      logic multiplier_on;
      logic [3:0] integer_ratio;
      logic [23:0] fraction_ratio;
      logic input_halver;
      logic clock_source_select;
   } acc_config_type;
endpackage

// File: hw/acc_compander.sv
// adc companding encoder, clock configuration registers and output fifo
// ==========================================================
// Summary of operation
// R1: field 2:1 picks linear, mu-law, A-law coding
// R2: mu-law code has all eight bits inverted
// R3: A-law code has even bits inverted
// R4: code sits in the top eight bits
// R5: mu-law uses 13 bits, A-law 12 bits
// R6: eight segments, finer steps at low level
// R7: sign bit 7, segment 6:4, mantissa 3:0
// R8: standard G.711 segment tables, 255 and 87.6
// R9: three-bit rate code selects filter set
// R10: filter timing assumes 256 times sample rate
// R11: software picks nearest listed rate code
// R12: power bit 5 turns multiplier on
// R13: software computes integer and fraction ratio
// R14: integer ratio kept between 5 and 13; not enforced here, any 4-bit value 0 to 15 is passed to config_out
// R15: multiplier output divided by 4, then 2
// R16: ratio bit 4 halves reference clock
// R17: fraction spread over three registers, 23:0
// R18: software aims multiplier near 90 MHz
// R19: clock select: 0 master, 1 multiplier
// R20: 16-bit control word, 7-bit address, 9 data
// R21: linear mode passes sample unchanged
// R22: code registered once per sample
`timescale 1ns/100ps

// ==========================================================
// fifo between encoder and audio interface
module acc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      // one bit wider than the pointers to tell full from empty
      logic [AW:0] count;
   } acc_fifo_state_type;

   acc_fifo_state_type st_r;
   acc_fifo_state_type st_nxt;
   logic push;
   logic pop;
   logic full;
   logic empty;

   // full and empty from one count, so a pointer wrap cannot alias them
   assign full = (st_r.count == (AW+1)'(DEPTH));
   assign empty = (st_r.count == '0);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st_r.mem[st_r.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data;
         st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule

// ==========================================================
// top: registers, clock selection, encoder
module acc_compander
   import acc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // control word write port
   input wire logic ctrl_valid,
   input wire acc_ctrl_word_type ctrl_word,
   // clock ticks in
   input wire logic master_tick,
   input wire logic multiplier_tick,
   // clock configuration out
   output acc_config_type config_out,
   output logic reference_tick,
   output logic system_tick,
   // linear samples from the adc
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [SAMPLE_W-1:0] sample_data,
   // words to the audio interface
   output logic word_valid,
   input wire logic word_ready,
   output logic [SAMPLE_W-1:0] word_data
);
   // enc_word and enc_valid form one register stage ahead of the fifo
   typedef struct packed {
      acc_regs_type regs;
      logic [SAMPLE_W-1:0] enc_word;
      logic enc_valid;
      logic [2:0] div_count;
      logic halver_phase;
      logic ref_tick;
      logic sys_tick;
   } acc_state_type;

   acc_state_type st_r;
   acc_state_type st_nxt;
   acc_mode_type mode;
   logic fifo_in_ready;
   logic [2:0] div_last;

   // ========================================================
   // shared arithmetic
   function automatic logic [11:0] magnitude_12(input logic [12:0] x);
      logic [12:0] m;
      m = x[12] ? (~x + 13'h0001) : x;
      // the most negative value clips to full scale
      magnitude_12 = m[12] ? 12'hfff : m[11:0];
   endfunction

   // highest set bit above bit zero; bit zero alone is segment zero
   function automatic logic [2:0] top_bit_seg(input logic [7:0] v);
      top_bit_seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (v[i]) begin
            top_bit_seg = 3'(i);
         end
      end
   endfunction

   // mu-law: 13-bit input, bias 33, eight segments
   function automatic logic [7:0] mulaw_code(input logic [12:0] x);
      logic [11:0] m;
      logic [12:0] v;
      logic [2:0] seg;
      logic [3:0] mant;
      m = magnitude_12(x);
      v = {1'b0, m} + MULAW_BIAS; // R8
      // biased full scale saturates to the top code
      if (v[12]) begin
         v = 13'h1fff;
      end
      seg = top_bit_seg(v[12:5]); // R6
      mant = 4'(v >> (seg + 3'h1));
      mulaw_code = {x[12], seg, mant} ^ MULAW_INVERT; // R7 R2
   endfunction

   // A-law: 12-bit input, segment 0 and 1 share step size
   function automatic logic [7:0] alaw_code(input logic [11:0] x);
      logic [11:0] m;
      logic [10:0] v;
      logic [2:0] seg;
      logic [3:0] mant;
      m = magnitude_12({x[11], x});
      v = m[11] ? 11'h7ff : m[10:0];
      seg = top_bit_seg({v[10:4], 1'b0}); // R6 R8
      // the two lowest segments both step by one count, so the
      // shift is one less than the segment and the leading one
      // above the mantissa is dropped
      if (seg == 3'h0) begin
         mant = v[3:0];
      end else begin
         mant = 4'(v >> (seg - 3'h1));
      end
      alaw_code = {~x[11], seg, mant} ^ ALAW_INVERT; // R7 R3
   endfunction

   // ========================================================
   // mode decode; reserved code behaves as linear
   always_comb begin
      unique case (st_r.regs.compand_control[COMP_LSB +: 2]) // R1
         COMP_MULAW: mode = MODE_MULAW;
         COMP_ALAW: mode = MODE_ALAW;
         COMP_LINEAR: mode = MODE_LINEAR;
         default: mode = MODE_LINEAR;
      endcase
   end

   // only the divide-by-two post setting is modelled; other codes give divide by 4
   assign div_last = (st_r.regs.clock_control[CLK_DIV_LSB +: 3] == CLK_DIV_TWO)
                     ? HALVED_DIV_LAST : FIXED_DIV_LAST; // R15

   // ========================================================
   // configuration view
   // fields come straight from the registers; reserved rate codes kept as written
   always_comb begin
      config_out.rate_code = st_r.regs.extra_control[RATE_LSB +: 3]; // R9 R10
      config_out.multiplier_on = st_r.regs.power_management_one[MULT_ON_BIT]; // R12
      config_out.integer_ratio = st_r.regs.multiplier_integer_ratio[3:0];
      config_out.fraction_ratio = {st_r.regs.multiplier_fraction_high[FRAC_HIGH_W-1:0],
                                   st_r.regs.multiplier_fraction_mid,
                                   st_r.regs.multiplier_fraction_low}; // R17
      config_out.input_halver = st_r.regs.multiplier_integer_ratio[HALVER_BIT]; // R16
      config_out.clock_source_select = st_r.regs.clock_control[CLK_SRC_BIT]; // R19
   end

   assign reference_tick = st_r.ref_tick;
   assign system_tick = st_r.sys_tick;
   // the stage takes a sample when empty or when it drains this cycle
   assign sample_ready = !st_r.enc_valid || fifo_in_ready;

   // ========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      // register writes; a write to address zero restores defaults
      // registers cannot be read back; unknown addresses are dropped
      if (ctrl_valid) begin // R20
         unique case (ctrl_word.addr)
            ADDR_SOFT_RESET: begin
               st_nxt.regs = {RST_POWER_ONE, RST_COMPAND, RST_CLOCK_CTL, RST_EXTRA,
                              RST_INT_RATIO, RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW};
            end
            ADDR_POWER_ONE: st_nxt.regs.power_management_one = ctrl_word.data;
            ADDR_COMPAND: st_nxt.regs.compand_control = ctrl_word.data;
            ADDR_CLOCK_CTL: st_nxt.regs.clock_control = ctrl_word.data;
            ADDR_EXTRA: st_nxt.regs.extra_control = ctrl_word.data;
            ADDR_INT_RATIO: st_nxt.regs.multiplier_integer_ratio = ctrl_word.data;
            ADDR_FRAC_HIGH: st_nxt.regs.multiplier_fraction_high = ctrl_word.data;
            ADDR_FRAC_MID: st_nxt.regs.multiplier_fraction_mid = ctrl_word.data;
            ADDR_FRAC_LOW: st_nxt.regs.multiplier_fraction_low = ctrl_word.data;
            default: ;
         endcase
      end

      // reference to the multiplier, optionally halved; the phase
      // restarts while the halver is off, so the first reference
      // tick after enabling it is always suppressed
      st_nxt.ref_tick = 1'b0;
      if (!config_out.input_halver) begin
         st_nxt.halver_phase = 1'b0;
      end
      if (master_tick) begin
         if (config_out.input_halver) begin // R16
            st_nxt.halver_phase = !st_r.halver_phase;
            st_nxt.ref_tick = st_r.halver_phase;
         end else begin
            st_nxt.ref_tick = 1'b1;
         end
      end

      // multiplier output through divide by 4 and optional 2;
      // with the multiplier off nothing counts
      st_nxt.sys_tick = 1'b0;
      if (config_out.multiplier_on && multiplier_tick) begin // R15
         if (st_r.div_count >= div_last) begin
            st_nxt.div_count = 3'h0;
         end else begin
            st_nxt.div_count = st_r.div_count + 3'h1;
         end
      end else if (!config_out.multiplier_on) begin
         // restart so the first tick after enabling is a full period
         st_nxt.div_count = 3'h0;
      end
      if (config_out.clock_source_select) begin // R19
         st_nxt.sys_tick = config_out.multiplier_on && multiplier_tick &&
                           (st_r.div_count >= div_last);
      end else begin
         st_nxt.sys_tick = master_tick;
      end

      // encoder stage: one registered word per accepted sample
      if (st_r.enc_valid && fifo_in_ready) begin
         st_nxt.enc_valid = 1'b0;
      end
      if (sample_valid && sample_ready) begin // R22
         st_nxt.enc_valid = 1'b1;
         unique case (mode)
            MODE_MULAW: begin
               st_nxt.enc_word = {mulaw_code(sample_data[SAMPLE_W-1 -: 13]),
                                  {(SAMPLE_W-CODE_W){1'b0}}}; // R5 R4
            end
            MODE_ALAW: begin
               st_nxt.enc_word = {alaw_code(sample_data[SAMPLE_W-1 -: 12]),
                                  {(SAMPLE_W-CODE_W){1'b0}}}; // R5 R4
            end
            MODE_LINEAR: st_nxt.enc_word = sample_data; // R21
         endcase
      end
   end

   // ========================================================
   // state registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_r.regs <= '{RST_POWER_ONE, RST_COMPAND, RST_CLOCK_CTL, RST_EXTRA,
                        RST_INT_RATIO, RST_FRAC_HIGH, RST_FRAC_MID, RST_FRAC_LOW};
         st_r.enc_word <= '0;
         st_r.enc_valid <= 1'b0;
         st_r.div_count <= 3'h0;
         st_r.halver_phase <= 1'b0;
         st_r.ref_tick <= 1'b0;
         st_r.sys_tick <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ========================================================
   // buffering toward the audio interface; a stalled reader
   // fills it and then holds off the adc through sample_ready
   acc_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(st_r.enc_valid),
      .in_ready(fifo_in_ready),
      .in_data(st_r.enc_word),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );
endmodule

// File: test/acc_compander_assertions.sv
// checker for the adc compander top ports
`timescale 1ns/100ps
module acc_compander_checker
   import acc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // control and ticks
   input wire logic ctrl_valid,
   input wire acc_ctrl_word_type ctrl_word,
   input wire logic master_tick,
   input wire logic multiplier_tick,
   input wire acc_config_type config_out,
   input wire logic reference_tick,
   input wire logic system_tick,
   // data
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [SAMPLE_W-1:0] sample_data,
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic [SAMPLE_W-1:0] word_data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // properties
   property p_hold; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
   property p_empty; !word_valid |-> sample_ready; endproperty
   property p_first; !word_valid && sample_valid && sample_ready |=> ##1 word_valid; endproperty
   property p_rate;
      ctrl_valid && ctrl_word.addr == ADDR_EXTRA |=> config_out.rate_code == $past(ctrl_word.data[3:1]);
   endproperty
   property p_on;
      ctrl_valid && ctrl_word.addr == ADDR_POWER_ONE |=> config_out.multiplier_on == $past(ctrl_word.data[5]);
   endproperty
   property p_ratio; ctrl_valid && ctrl_word.addr == ADDR_INT_RATIO
      |=> {config_out.input_halver, config_out.integer_ratio} == $past(ctrl_word.data[4:0]); endproperty
   property p_frac; ctrl_valid && ctrl_word.addr == ADDR_FRAC_HIGH
      |=> config_out.fraction_ratio[23:18] == $past(ctrl_word.data[5:0]); endproperty
   property p_sel; ctrl_valid && ctrl_word.addr == ADDR_CLOCK_CTL
      |=> config_out.clock_source_select == $past(ctrl_word.data[8]); endproperty
   property p_mclk; master_tick && !config_out.clock_source_select |=> system_tick; endproperty
   property p_off; config_out.clock_source_select && !config_out.multiplier_on |=> !system_tick; endproperty
   property p_ref; master_tick && !config_out.input_halver |=> reference_tick; endproperty
   // ==========================================================
   // assertions
   a_hold: assert property (p_hold) else $error("stalled word changed");
   a_empty: assert property (p_empty) else $error("refused sample while empty");
   a_first: assert property (p_first) else $error("word late");
   a_rate: assert property (p_rate) else $error("rate code not stored");
   a_on: assert property (p_on) else $error("multiplier enable not stored");
   a_ratio: assert property (p_ratio) else $error("ratio not stored");
   a_frac: assert property (p_frac) else $error("fraction high not stored");
   a_sel: assert property (p_sel) else $error("clock select not stored");
   a_mclk: assert property (p_mclk) else $error("master tick lost");
   a_off: assert property (p_off) else $error("tick while multiplier off");
   a_ref: assert property (p_ref) else $error("reference tick lost");
   c_stall: cover property (word_valid && !word_ready);
   c_full: cover property (!sample_ready);
   c_mult: cover property (system_tick && config_out.clock_source_select);
endmodule

bind acc_compander acc_compander_checker acc_compander_checker_i (.clock(clock), .rst_b(rst_b),
   .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word), .master_tick(master_tick),
   .multiplier_tick(multiplier_tick), .config_out(config_out), .reference_tick(reference_tick),
   .system_tick(system_tick), .sample_valid(sample_valid), .sample_ready(sample_ready),
   .sample_data(sample_data), .word_valid(word_valid), .word_ready(word_ready),
   .word_data(word_data));

// File: test/acc_host_model.sv
// host sink for audio words, stalls at a given percentage
`timescale 1ns/100ps
module acc_host_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // stall control and handshake
   input wire logic [7:0] stall_pct,
   output logic word_ready
);
   // ==========================================================
   // registered ready, so stalls start one cycle late like real logic
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) word_ready <= 1'b0;
      else word_ready <= $urandom_range(99) >= stall_pct;
   end
endmodule

// File: test/tb_top.sv
// self-checking bench for the adc compander
`timescale 1ns/100ps
module tb_top;
   import acc_pkg::*;
   logic clock, rst_b, ctrl_valid, master_tick, multiplier_tick, sample_valid;
   logic reference_tick, system_tick, sample_ready, word_valid, word_ready;
   acc_ctrl_word_type ctrl_word;
   acc_config_type config_out, e;
   logic [23:0] sample_data, word_data;
   logic [8:0] rm [int];
   logic [23:0] q [$];
   logic [7:0] stall;
   logic [6:0] adr [11] = '{7'h00, 7'h01, 7'h05, 7'h06, 7'h07, 7'h24, 7'h25, 7'h26, 7'h27, 7'h10, 7'h7f};
   logic [23:0] edg [4] = '{24'h800000, 24'h7fffff, 24'h000000, 24'hffffff};
   int bad_count, cmp_count, n_sys, n_ref, s0, r0, k;
   bit ok, tk;
   acc_compander acc_compander_i (.clock(clock), .rst_b(rst_b), .ctrl_valid(ctrl_valid),
      .ctrl_word(ctrl_word), .master_tick(master_tick), .multiplier_tick(multiplier_tick),
      .config_out(config_out), .reference_tick(reference_tick), .system_tick(system_tick),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   acc_host_model acc_host_model_i (.clock(clock), .rst_b(rst_b), .stall_pct(stall),
      .word_ready(word_ready));
   // ==========================================================
   // reference model
   function automatic logic [7:0] mu(input logic [23:0] s);
      int x, m, g;
      x = $signed(s[23:11]);
      m = (x < 0 ? -x : x) + 33;
      if (m > 4095) m = 8191;
      g = 0;
      for (int i = 6; i <= 12; i++) if (m >= (1 << i)) g = i - 5;
      return {x < 0, 3'(g), 4'(m >> (g + 1))} ^ MULAW_INVERT;
   endfunction
   function automatic logic [7:0] al(input logic [23:0] s);
      int x, m, g;
      x = $signed(s[23:12]);
      m = x < 0 ? -x : x;
      if (m > 2047) m = 2047;
      g = 0;
      for (int i = 4; i <= 10; i++) if (m >= (1 << i)) g = i - 3;
      return {x >= 0, 3'(g), 4'(g == 0 ? m : m >> (g - 1))} ^ ALAW_INVERT;
   endfunction
   // ==========================================================
   // shared tasks
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task defaults;
      rm.delete();
      rm[1] = RST_POWER_ONE; rm[5] = RST_COMPAND; rm[6] = RST_CLOCK_CTL; rm[7] = RST_EXTRA;
      rm[36] = RST_INT_RATIO; rm[37] = RST_FRAC_HIGH; rm[38] = RST_FRAC_MID; rm[39] = RST_FRAC_LOW;
   endtask
   task cfg_chk;
      e = '{rm[7][3:1], rm[1][5], rm[36][3:0], {rm[37][5:0], rm[38], rm[39]}, rm[36][4], rm[6][8]};
      chk(config_out, e);
   endtask
   task wr(input logic [6:0] a, input logic [8:0] d);
      ctrl_valid <= 1'b1;
      ctrl_word <= '{a, d};
      @(posedge clock);
      ctrl_valid <= 1'b0;
      if (a == 7'h00) defaults();
      else if (rm.exists(a)) rm[a] = d;
      @(posedge clock);
      #1 cfg_chk();
      @(posedge clock);
   endtask
   task push(input logic [23:0] d, input int lim);
      sample_valid <= 1'b1;
      sample_data <= d;
      tk = 0;
      for (int i = 0; i < lim && !tk; i++) begin
         #1 ok = sample_ready;
         @(posedge clock);
         tk = ok;
      end
      if (tk) q.push_back(rm[5][2:1] == COMP_MULAW ? {mu(d), 16'h0} :
         rm[5][2:1] == COMP_ALAW ? {al(d), 16'h0} : d);
   endtask
   task drain;
      sample_valid <= 1'b0;
      for (k = 0; k < 3000 && q.size() > 0; k++) @(posedge clock);
      chk(q.size(), 0);
   endtask
   task tcase(input bit m, input bit t, input int es, input int er);
      s0 = n_sys;
      r0 = n_ref;
      repeat (32) begin
         master_tick <= m;
         multiplier_tick <= t;
         @(posedge clock);
         master_tick <= 1'b0;
         multiplier_tick <= 1'b0;
         @(posedge clock);
      end
      repeat (4) @(posedge clock);
      chk(n_sys - s0, es);
      chk(n_ref - r0, er);
   endtask
   // ==========================================================
   // clock, monitors, watchdog
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      if (system_tick === 1'b1) n_sys++;
      if (reference_tick === 1'b1) n_ref++;
      if (word_valid === 1'b1 && word_ready === 1'b1)
         chk(word_data, q.size() ? q.pop_front() : ~word_data);
   end
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   // ==========================================================
   // tests
   initial begin
      void'($urandom(32'h5d5e));
      {rst_b, ctrl_valid, master_tick, multiplier_tick, sample_valid} = '0;
      ctrl_word = '0;
      sample_data = '0;
      stall = 8'h00;
      defaults();
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1 cfg_chk();
      @(posedge clock);
      for (int i = 0; i < 8; i++) wr(ADDR_EXTRA, 9'(i << 1));
      for (int i = 6; i < 13; i++) wr(ADDR_INT_RATIO, 9'(i));
      wr(ADDR_FRAC_HIGH, 9'h021);
      wr(ADDR_FRAC_MID, 9'h161);
      wr(ADDR_FRAC_LOW, 9'h020);
      repeat (30) wr(adr[$urandom_range(10)], 9'($urandom));
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_COMPAND, 9'(m << 1));
         stall = 8'(m * 30);
         for (int i = 0; i < 40; i++) push(i < 4 ? edg[i] : 24'($urandom), 500);
         drain();
      end
      $display("test coding done");
      stall = 8'd100;
      k = 0;
      do begin
         push(24'($urandom), 4);
         k += tk;
      end while (tk && k < 40);
      chk(k, FIFO_DEPTH + 1);
      stall = 8'd50;
      drain();
      $display("test buffer done");
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      defaults();
      stall = 8'd0;
      @(posedge clock);
      tcase(0, 1, 0, 0);
      wr(ADDR_POWER_ONE, 9'h020);
      tcase(0, 1, 4, 0);
      wr(ADDR_CLOCK_CTL, 9'h100);
      tcase(0, 1, 8, 0);
      wr(ADDR_CLOCK_CTL, 9'h040);
      tcase(1, 1, 32, 32);
      wr(ADDR_INT_RATIO, 9'h018);
      tcase(1, 0, 32, 16);
      $display("test clocks done");
      end_sim();
   end
endmodule
